// [linear_array_scan_sequencer.sv]
// Scan sequencer of a 128-pixel linear sensor: start capture, hold, reset window, readout.
`include "las_defs.svh"
module linear_array_scan_sequencer
  import las_pkg::*;
#(
  parameter int PIXELS = `LAS_PIXELS,
  parameter int RESET_CLKS = `LAS_RESET_CLKS,
  parameter int PIX_W = `LAS_PIX_W,
  parameter int FIFO_DEPTH = `LAS_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic scan_start_i,
  input wire logic scan_clk_i,
  input wire logic [PIX_W-1:0] pixel_data_i,
  input wire logic pixel_valid_i,
  output logic pixel_ready_o,
  output logic pixel_hold_o,
  output logic integ_reset_o,
  output logic [PIX_W-1:0] analog_pixel_output_o,
  output logic analog_pixel_output_oe_o,
  output logic scan_active_o,
  output logic underrun_o,
  output logic start_early_o
);
  localparam logic [7:0] LAST_PIX = 8'(PIXELS);
  localparam logic [7:0] RST_LAST = 8'(RESET_CLKS);
  localparam logic [11:0] CT_CYCLES = 12'(`LAS_CT_CYCLES);

  // ==========================================================
  // Pin synchronisers
  logic clk_s1, clk_s2, clk_s3;
  logic start_s1, start_s2, start_s3;
  logic clk_rise;
  logic start_rise;

  // Both pins cross two flops; the third flop only serves edge detection.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
      start_s3 <= 1'b0;
    end
    else
    begin
      clk_s1 <= scan_clk_i;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      start_s1 <= scan_start_i;
      start_s2 <= start_s1;
      start_s3 <= start_s2;
    end
  end

  assign clk_rise = clk_s2 & ~clk_s3;
  assign start_rise = start_s2 & ~start_s3;

  // ==========================================================
  // Pixel buffer
  logic fifo_valid;
  logic fifo_pop;
  logic [PIX_W-1:0] fifo_data;

  pixel_fifo #(
    .WIDTH(PIX_W),
    .DEPTH(FIFO_DEPTH)
  ) pixel_fifo_i (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .in_valid_i(pixel_valid_i),
    .in_ready_o(pixel_ready_o),
    .in_data_i(pixel_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  // ==========================================================
  // Sequencer state
  scan_state_e state, next_state;
  logic [7:0] pos, next_pos;
  logic [11:0] gap, next_gap;
  logic next_hold;
  logic next_reset;
  logic [PIX_W-1:0] next_data;
  logic next_oe;
  logic next_underrun;
  logic next_early;
  logic next_active;
  logic capture;

  // A start bit sampled high on a clock rise while idle is captured.
  assign capture = clk_rise && start_s2 && (state == ST_IDLE);
  // One sample leaves the buffer for every presented pixel while the buffer is not empty.
  assign fifo_pop = fifo_valid && clk_rise &&
                    ((capture) || (state == ST_SCAN && pos != LAST_PIX));

  // Steps the pixel position and derives hold, reset window and output drive.
  always_comb
  begin
    next_state = state;
    next_pos = pos;
    next_gap = (gap != '0) ? gap - 1'b1 : gap;
    next_hold = start_rise && (state == ST_IDLE);
    next_reset = integ_reset_o;
    next_data = analog_pixel_output_o;
    next_oe = analog_pixel_output_oe_o;
    next_underrun = underrun_o;
    next_early = start_early_o;
    case (state)
      ST_IDLE:
      begin
        next_oe = 1'b0;
        if (capture)
        begin
          next_state = ST_SCAN;
          next_pos = 8'h01;
          next_reset = 1'b1;
          next_oe = 1'b1;
          next_data = fifo_valid ? fifo_data : '0;
          next_underrun = !fifo_valid;
          next_early = (gap != '0);
        end
      end
      ST_SCAN:
      begin
        if (clk_rise)
        begin
          if (pos == LAST_PIX)
          begin
            next_state = ST_IDLE;
            next_pos = 8'h00;
            next_oe = 1'b0;
            next_data = '0;
            next_gap = CT_CYCLES;
          end
          else
          begin
            next_pos = pos + 8'h01;
            next_data = fifo_valid ? fifo_data : analog_pixel_output_o;
            next_underrun = underrun_o | !fifo_valid;
          end
          if (pos == RST_LAST)
          begin
            next_reset = 1'b0;
          end
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_pos = 8'h00;
        next_oe = 1'b0;
        next_reset = 1'b0;
      end
    endcase
    next_active = (next_state == ST_SCAN);
  end

  // Registers the sequencer state; all outputs except pixel_ready_o come from here.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= ST_IDLE;
      pos <= 8'h00;
      gap <= 12'h000;
      pixel_hold_o <= 1'b0;
      integ_reset_o <= 1'b0;
      analog_pixel_output_o <= '0;
      analog_pixel_output_oe_o <= 1'b0;
      scan_active_o <= 1'b0;
      underrun_o <= 1'b0;
      start_early_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pos <= next_pos;
      gap <= next_gap;
      pixel_hold_o <= next_hold;
      integ_reset_o <= next_reset;
      analog_pixel_output_o <= next_data;
      analog_pixel_output_oe_o <= next_oe;
      scan_active_o <= next_active;
      underrun_o <= next_underrun;
      start_early_o <= next_early;
    end
  end

  // ==========================================================
  // Assertions
  a_start_capture: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    capture |=> (pos == 8'h01) && analog_pixel_output_oe_o && scan_active_o)
    else $error("Start bit was not captured.");

  a_hold_on_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (start_rise && state == ST_IDLE) |=> pixel_hold_o ##1 !pixel_hold_o)
    else $error("Hold did not pulse on the start edge.");

  a_pixel_step: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (clk_rise && state == ST_SCAN && pos != LAST_PIX) |=> (pos == $past(pos) + 8'h01))
    else $error("Pixel position did not advance by one.");

  a_pixel_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (!clk_rise && state == ST_SCAN) |=> $stable(pos) && $stable(analog_pixel_output_o))
    else $error("Output changed without a clock step.");

  a_reset_window: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    integ_reset_o == (state == ST_SCAN && pos >= 8'h01 && pos <= RST_LAST))
    else $error("Integrator reset outside the first clocks.");

  a_end_float: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (clk_rise && state == ST_SCAN && pos == LAST_PIX) |=> !analog_pixel_output_oe_o &&
    (state == ST_IDLE) && (gap == CT_CYCLES))
    else $error("Final clock did not end the scan.");

  a_idle_float: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state == ST_IDLE && $past(state) == ST_IDLE) |-> !analog_pixel_output_oe_o)
    else $error("Output driven outside the output phase.");
endmodule

// [las_defs.svh]
// Constants of the linear array scan sequencer.
// Notes on behaviour
// - A start bit seen high on a sensor clock rise while idle begins the readout.
// - A rising start input while idle pulses the hold that freezes all samples; reset starts at the capture.
// - Each sensor clock step presents the next of the 128 pixels on the output.
// - Integrators stay in reset for the first 18 clocks and are released on the 19th.
// - The 129th clock rise ends the scan and floats the pixel output.
// - Outside the output phase the pixel output stays floated.
`ifndef LAS_DEFS_SVH
`define LAS_DEFS_SVH
`define LAS_PIXELS 128
`define LAS_RESET_CLKS 18
`define LAS_CLK_NS 8
`define LAS_CT_NS 20000
`define LAS_CT_CYCLES ((`LAS_CT_NS + `LAS_CLK_NS - 1) / `LAS_CLK_NS)
`define LAS_FIFO_DEPTH 4
`define LAS_PIX_W 8
`endif

// [las_pkg.sv]
// Types shared by the scan sequencer files.
package las_pkg;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SCAN = 1'b1
  } scan_state_e;
endpackage

// [pixel_fifo.sv]
// Small FIFO that buffers pixel samples ahead of the output stage.
module pixel_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic do_push;
  logic do_pop;
  logic next_ready;

  // Advances a pointer and wraps it at the depth, so any depth works.
  function automatic logic [AW-1:0] step_ptr(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Empty comes from the count; ready is registered so that the pin comes from a flop.
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign do_push = in_valid_i & in_ready_o;
  assign do_pop = out_ready_i & out_valid_o;

  // Pointers wrap at the depth so any depth works.
  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (do_push)
    begin
      next_wr_ptr = step_ptr(wr_ptr);
    end
    if (do_pop)
    begin
      next_rd_ptr = step_ptr(rd_ptr);
    end
    if (do_push && !do_pop)
    begin
      next_count = count + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      next_count = count - 1'b1;
    end
    next_ready = (next_count != DEPTH_C);
  end

  // Registers the pointers.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready_o <= next_ready;
    end
  end

  // Data array has no reset, it is only read when occupied.
  always_ff @(posedge clk_sys_i)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

// [host_model.sv]
// Host model that drives the sensor start and clock pins.
module host_model (
  input wire logic clk_sys_i,
  output logic scan_start_o,
  output logic scan_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both pins idle low until a scan is requested.
  initial
  begin
    scan_start_o = 1'b0;
    scan_clk_o = 1'b0;
  end
  // One clock phase lasts four system cycles, above the three the sync needs.
  task automatic phase(input logic lvl);
    scan_clk_o = lvl;
    repeat (4) @(negedge clk_sys_i);
  endtask
  // One scan of 129 rises; a stray start may be raised ahead of rise 50.
  task automatic scan(input int gap, input bit stray);
    repeat (gap) @(negedge clk_sys_i);
    scan_start_o = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    for (int k = 1; k <= 129; k++)
    begin
      phase(1'b1);
      // Start drops with the clock fall, well before the next rise.
      scan_start_o = stray && (k == 49);
      phase(1'b0);
    end
  endtask
endmodule

// [linear_array_scan_sequencer_tb.sv]
// Self-checking testbench of the scan sequencer with its host model.
`include "las_defs.svh"
module linear_array_scan_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic nrst_i;
  logic [7:0] pixel_data_i;
  logic pixel_valid_i;
  logic pixel_ready_o, pixel_hold_o, integ_reset_o, oe, scan_active_o, underrun_o, start_early_o;
  logic [7:0] pix;
  wire logic scan_start, scan_clk;
  int bad_count = 0;
  int n_checks = 0;
  int hold_cnt = 0;
  // The system clock toggles every half period of 4 ns.
  always #4 clk_sys_i = ~clk_sys_i;
  // Counts cycles with the hold high, so a pulse wider than one cycle shows.
  always @(posedge clk_sys_i) if (pixel_hold_o === 1'b1) hold_cnt++;
  host_model host_model_i (.clk_sys_i(clk_sys_i), .scan_start_o(scan_start),
    .scan_clk_o(scan_clk));
  linear_array_scan_sequencer linear_array_scan_sequencer_i (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .scan_start_i(scan_start), .scan_clk_i(scan_clk),
    .pixel_data_i(pixel_data_i), .pixel_valid_i(pixel_valid_i), .pixel_ready_o(pixel_ready_o),
    .pixel_hold_o(pixel_hold_o), .integ_reset_o(integ_reset_o), .analog_pixel_output_o(pix),
    .analog_pixel_output_oe_o(oe), .scan_active_o(scan_active_o), .underrun_o(underrun_o),
    .start_early_o(start_early_o));
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // A wait that runs out counts as a mismatch and closes the run.
  task automatic give_up();
    bad_count++;
    stop_test();
  endtask
  // Offers words lo..hi in order, one per taking edge.
  task automatic feed(input int lo, input int hi);
    int t;
    pixel_valid_i = 1'b1;
    for (int i = lo; i <= hi; i++)
    begin
      pixel_data_i = i[7:0];
      for (t = 0; t < 3000 && pixel_ready_o !== 1'b1; t++) @(negedge clk_sys_i);
      if (t == 3000) give_up();
      @(negedge clk_sys_i);
    end
    pixel_valid_i = 1'b0;
  endtask
  // Samples the outputs five cycles after each sensor clock rise.
  task automatic watch(input bit fed, input bit early);
    int t;
    for (int k = 1; k <= 129; k++)
    begin
      for (t = 0; t < 4000 && scan_clk !== 1'b0; t++) @(negedge clk_sys_i);
      for (t = t; t < 4000 && scan_clk !== 1'b1; t++) @(negedge clk_sys_i);
      if (t == 4000) give_up();
      repeat (5) @(negedge clk_sys_i);
      if (k <= 128)
      begin
        check("oe", oe, 8'h01);
        check("active", scan_active_o, 8'h01);
        if (fed) check("pixel", pix, k[7:0]);
        check("integ_reset", integ_reset_o, (k <= 18) ? 8'h01 : 8'h00);
      end
      else
      begin
        check("oe_end", oe, 8'h00);
        check("active_end", scan_active_o, 8'h00);
      end
      if (k == 1) check("start_early", start_early_o, {7'h0, early});
      if (k == 128) check("underrun", underrun_o, {7'h0, !fed});
    end
  endtask
  // One whole scan; fed scans fill the FIFO until it refuses before starting.
  task automatic run(input bit fed, input int gap, input bit stray, input bit early, int n);
    if (fed)
    begin
      feed(1, 4);
      check("ready_full", pixel_ready_o, 8'h00);
      @(negedge clk_sys_i); // Lets an edge pass before valid rises again.
    end
    fork
      host_model_i.scan(gap, stray);
      watch(fed, early);
      if (fed) feed(5, 128);
    join
    check("oe_idle", oe, 8'h00);
    check("hold_count", hold_cnt[7:0], n[7:0]);
  endtask
  // Main sequence: reset, fed scan, early unfed scan, late scan with a stray start.
  initial
  begin
    nrst_i = 1'b0;
    pixel_valid_i = 1'b0;
    pixel_data_i = 8'h00;
    repeat (8) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check("oe_reset", oe, 8'h00);
    check("ready_reset", pixel_ready_o, 8'h01);
    check("active_reset", scan_active_o, 8'h00);
    run(1'b1, `LAS_CT_CYCLES + 10, 1'b0, 1'b0, 1);
    run(1'b0, 10, 1'b0, 1'b1, 2);
    run(1'b1, `LAS_CT_CYCLES + 10, 1'b1, 1'b0, 3);
    stop_test();
  end
endmodule
